// >>> core/frso_top.sv
// fastening result record formatter with asynchronous serial transmitter
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "frso_regs.svh"
// Overview of operation
// - station number 1..25, default 1
// - filter: all, errors only, or nothing
// - framing: hash-CR, hash-LF, ENQ..end marker
// - baud codes 0..2: 4800, 9600, 19200
// - seven or eight data bits
// - one or two stop bits
// - parity none, even or odd
// - torque field on enable
// - pulse count field on enable
// - duration field on enable
// - verdict field on enable
// - waveform: never, always, after reject
// - angle field on enable
// - free-run angle field, default off
// - seating angle field, default off
// - torque-angle slope field, default off
// - waveform samples binary two or ASCII four
// - identifier field, default off
// - identifier 1..48 digits, pad with '0'
module frso_top #(
  parameter int BIT_CYC_0 = `FRSO_CLK_HZ / `FRSO_BPS_0,
  parameter int BIT_CYC_1 = `FRSO_CLK_HZ / `FRSO_BPS_1,
  parameter int BIT_CYC_2 = `FRSO_CLK_HZ / `FRSO_BPS_2
)(
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire logic                  res_valid,
  input  wire frso_pkg::frso_result_s res_data,
  output logic                       res_ready,
  input  wire logic                  wave_valid,
  input  wire frso_pkg::frso_wave_s  wave_data,
  output logic                       wave_ready,
  output logic                       txd
);

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [7:0] hexChar(input logic [3:0] n);
    hexChar = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  function automatic logic [11:0] buildFrame(input logic [7:0] d, input logic len8,
                                             input logic [1:0] par);
    logic [11:0] f;
    logic        p;
    f = 12'hfff;
    p = len8 ? ^d : ^d[6:0];
    if (par == 2'h2)
      p = ~p;
    f[0] = 1'b0;
    if (len8)
    begin
      f[8:1] = d;
      if (par == 2'h1 || par == 2'h2)
        f[9] = p;
    end
    else
    begin
      f[7:1] = d[6:0];
      if (par == 2'h1 || par == 2'h2)
        f[8] = p;
    end
    buildFrame = f;
  endfunction

  // --------------------------------------------------------------
  // register bus
  // --------------------------------------------------------------
  logic [31:0]                 cfg0Ff;
  logic [31:0]                 cfg1Ff;
  logic [31:0]                 idMemFf [`FRSO_ID_WORDS];
  logic                        wrPendFf;
  logic [7:0]                  wrAddrFf;
  logic                        rdWaitFf;
  logic [7:0]                  rdAddrFf;
  logic [31:0]                 hrdataFf;
  logic [7:0]                  recCntFf;
  logic [7:0]                  dropCntFf;
  logic                        txBusyFf;
  frso_pkg::frso_state_e       stateFf;
  logic                        addrPhase;
  logic [31:0]                 cfg0New;
  logic [31:0]                 cfg1New;
  logic [31:0]                 regRead;

  assign addrPhase = hsel & hready & htrans[1];
  assign hreadyout = ~rdWaitFf;
  assign hresp     = 1'b0;
  assign hrdata    = hrdataFf;
  assign cfg0New   = hwdata & `FRSO_CFG0_MASK;
  assign cfg1New   = hwdata & `FRSO_CFG1_MASK;

  always_comb
  begin
    regRead = 32'h0000_0000;
    if (rdAddrFf == `FRSO_CFG0_OFS)
      regRead = cfg0Ff;
    else if (rdAddrFf == `FRSO_CFG1_OFS)
      regRead = cfg1Ff;
    else if (rdAddrFf == `FRSO_STAT_OFS)
      regRead = {8'h00, dropCntFf, recCntFf, 6'h00, txd,
                 (stateFf != frso_pkg::ST_IDLE) | txBusyFf};
    else if (rdAddrFf >= `FRSO_ID_OFS && rdAddrFf <= `FRSO_ID_LAST)
      regRead = idMemFf[rdAddrFf[5:2] - 4'h0];
  end

  // reads take one wait state so a write just before is always visible
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrPendFf <= 1'b0;
      wrAddrFf <= 8'h00;
      rdWaitFf <= 1'b0;
      rdAddrFf <= 8'h00;
      hrdataFf <= 32'h0000_0000;
    end
    else
    begin
      wrPendFf <= addrPhase & hwrite;
      rdWaitFf <= addrPhase & ~hwrite;
      if (addrPhase)
      begin
        wrAddrFf <= {haddr[7:2], 2'b00};
        rdAddrFf <= {haddr[7:2], 2'b00};
      end
      if (rdWaitFf)
        hrdataFf <= regRead;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      cfg0Ff <= `FRSO_CFG0_RST;
    else if (wrPendFf && wrAddrFf == `FRSO_CFG0_OFS)
    begin
      // out-of-range station numbers leave the old value in place
      if (cfg0New[`FRSO_STN] != 5'h00 && cfg0New[`FRSO_STN] <= `FRSO_STN_MAX)
        cfg0Ff <= cfg0New;
      else
        cfg0Ff <= {cfg0New[31:5], cfg0Ff[`FRSO_STN]};
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      cfg1Ff <= `FRSO_CFG1_RST;
    else if (wrPendFf && wrAddrFf == `FRSO_CFG1_OFS)
    begin
      if (cfg1New[`FRSO_IDCNT] != 6'h00 && cfg1New[`FRSO_IDCNT] <= `FRSO_ID_MAX)
        cfg1Ff <= cfg1New;
      else
        cfg1Ff <= {2'b00, cfg1Ff[`FRSO_IDCNT], cfg1New[23:0]};
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < `FRSO_ID_WORDS; i++)
        idMemFf[i] <= 32'h0000_0000;
    end
    else if (wrPendFf && wrAddrFf >= `FRSO_ID_OFS && wrAddrFf <= `FRSO_ID_LAST)
      idMemFf[wrAddrFf[5:2]] <= hwdata;
  end

  // --------------------------------------------------------------
  // transmitter
  // --------------------------------------------------------------
  logic [11:0]                 shiftFf;
  logic [3:0]                  bitsLeftFf;
  logic [14:0]                 baudCntFf;
  logic [14:0]                 bitCycFf;
  logic                        load;
  logic [7:0]                  chr;
  logic [14:0]                 bitCycSel;
  logic [3:0]                  nbits;

  always_comb
  begin
    case (cfg0Ff[`FRSO_BAUD])
      2'h0:    bitCycSel = 15'(BIT_CYC_0 - 1);
      2'h2:    bitCycSel = 15'(BIT_CYC_2 - 1);
      default: bitCycSel = 15'(BIT_CYC_1 - 1);
    endcase
    // count includes the stop bits so they are timed in full before the next load
    nbits = 4'h9 + {3'h0, cfg0Ff[`FRSO_LEN8]} + {3'h0, cfg0Ff[`FRSO_STOP2]}
          + {3'h0, cfg0Ff[`FRSO_PAR] == 2'h1 || cfg0Ff[`FRSO_PAR] == 2'h2};
  end

  assign txd = shiftFf[0];

  // format is latched per character, so a setting change never splits one
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shiftFf    <= 12'hfff;
      bitsLeftFf <= 4'h0;
      baudCntFf  <= 15'h0000;
      bitCycFf   <= 15'h0000;
      txBusyFf   <= 1'b0;
    end
    else if (load)
    begin
      shiftFf    <= buildFrame(chr, cfg0Ff[`FRSO_LEN8], cfg0Ff[`FRSO_PAR]);
      bitsLeftFf <= nbits;
      baudCntFf  <= bitCycSel;
      bitCycFf   <= bitCycSel;
      txBusyFf   <= 1'b1;
    end
    else if (txBusyFf)
    begin
      if (baudCntFf == 15'h0000)
      begin
        shiftFf    <= {1'b1, shiftFf[11:1]};
        bitsLeftFf <= bitsLeftFf - 4'h1;
        baudCntFf  <= bitCycFf;
        txBusyFf   <= (bitsLeftFf != 4'h1);
      end
      else
        baudCntFf <= baudCntFf - 15'h0001;
    end
  end

  // --------------------------------------------------------------
  // record sequencer
  // --------------------------------------------------------------
  frso_pkg::frso_result_s      resFf;
  logic                        waveGoFf;
  logic                        tookFf;
  logic [5:0]                  subFf;
  logic [2:0]                  fIdxFf;
  frso_pkg::frso_state_e       nxt_state;
  logic [5:0]                  nxt_sub;
  logic [2:0]                  nxt_fIdx;
  logic                        emit;
  logic                        step;
  logic                        sendRec;
  logic                        sendWave;
  logic [3:0]                  tens;
  logic [4:0]                  ones;
  logic [7:0]                  idByte;
  logic [3:0]                  nib;
  logic                        lastNib;
  logic                        lastWaveCh;
  logic [1:0]                  wsel;

  assign wsel     = cfg1Ff[`FRSO_WSEL];
  assign sendRec  = (cfg0Ff[`FRSO_FLT] == 2'h0) ||
                    (cfg0Ff[`FRSO_FLT] == 2'h1 && res_data.reportErr);
  assign sendWave = res_data.hasWave && cfg0Ff[`FRSO_FLT] != 2'h2 &&
                    (wsel == 2'h1 || (wsel == 2'h2 && res_data.reject));
  assign tens     = (cfg0Ff[`FRSO_STN] >= 5'd20) ? 4'h2 :
                    (cfg0Ff[`FRSO_STN] >= 5'd10) ? 4'h1 : 4'h0;
  assign ones     = cfg0Ff[`FRSO_STN] - 5'(tens) * 5'd10;
  assign idByte   = idMemFf[subFf[5:2]][{subFf[1:0], 3'b000} +: 8];
  assign nib      = (fIdxFf == `FRSO_VERDICT) ? resFf.field[fIdxFf][3:0] :
                    resFf.field[fIdxFf][{~subFf[1:0], 2'b00} +: 4];
  assign lastNib  = (fIdxFf == `FRSO_VERDICT) ? 1'b1 : (subFf[1:0] == 2'h3);
  assign lastWaveCh = cfg1Ff[`FRSO_WENC] ? (subFf[1:0] == 2'h3) : subFf[0];
  // one dead cycle after every hand-off, even for a record that is filtered out
  assign res_ready  = (stateFf == frso_pkg::ST_IDLE) & ~tookFf;
  assign step       = ~emit | ~txBusyFf;
  assign load       = emit & ~txBusyFf;
  assign wave_ready = (stateFf == frso_pkg::ST_DRAIN) ? wave_valid : (load & lastWaveCh &
                      (stateFf == frso_pkg::ST_WAVE));

  always_comb
  begin
    nxt_state = stateFf;
    nxt_sub   = subFf;
    nxt_fIdx  = fIdxFf;
    emit      = 1'b0;
    chr       = `FRSO_CH_ZERO;
    case (stateFf)
      frso_pkg::ST_IDLE:
      begin
        nxt_sub  = 6'h00;
        nxt_fIdx = 3'h0;
        if (res_valid && res_ready)
          nxt_state = sendRec ? frso_pkg::ST_HEAD : sendWave ? frso_pkg::ST_WAVE :
                      res_data.hasWave ? frso_pkg::ST_DRAIN : frso_pkg::ST_IDLE;
      end
      frso_pkg::ST_HEAD:
      begin
        emit = 1'b1;
        chr  = (cfg0Ff[`FRSO_FORM] == 2'h2) ? `FRSO_CH_ENQ : `FRSO_CH_HASH;
        nxt_state = frso_pkg::ST_STN;
      end
      frso_pkg::ST_STN:
      begin
        emit = 1'b1;
        chr  = subFf[0] ? (`FRSO_CH_ZERO + {3'h0, ones}) :
                          (`FRSO_CH_ZERO + {4'h0, tens});
        nxt_sub = subFf + 6'h01;
        if (subFf[0])
        begin
          nxt_sub   = 6'h00;
          nxt_state = frso_pkg::ST_FIELD;
        end
      end
      frso_pkg::ST_FIELD:
      begin
        // fields 0..7
        emit = cfg1Ff[fIdxFf];
        chr  = hexChar(nib);
        nxt_sub = subFf + 6'h01;
        if (!emit || lastNib)
        begin
          nxt_sub  = 6'h00;
          nxt_fIdx = fIdxFf + 3'h1;
          if (fIdxFf == 3'h7)
            nxt_state = frso_pkg::ST_IDD;
        end
      end
      frso_pkg::ST_IDD:
      begin
        emit = cfg1Ff[`FRSO_IDEN] && cfg1Ff[`FRSO_IDCNT] != 6'h00;
        chr  = (idByte == 8'h00) ? `FRSO_CH_ZERO : idByte;
        nxt_sub = subFf + 6'h01;
        if (!emit || subFf == cfg1Ff[`FRSO_IDCNT] - 6'h01)
        begin
          nxt_sub   = 6'h00;
          nxt_state = frso_pkg::ST_TERM;
        end
      end
      frso_pkg::ST_TERM:
      begin
        emit = 1'b1;
        case (cfg0Ff[`FRSO_FORM])
          2'h1:    chr = `FRSO_CH_LF;
          2'h2:    chr = `FRSO_CH_END;
          default: chr = `FRSO_CH_CR;
        endcase
        nxt_state = waveGoFf ? frso_pkg::ST_WAVE :
                    resFf.hasWave ? frso_pkg::ST_DRAIN : frso_pkg::ST_IDLE;
      end
      frso_pkg::ST_WAVE:
      begin
        emit = wave_valid;
        if (cfg1Ff[`FRSO_WENC])
          chr = hexChar(wave_data.sample[{~subFf[1:0], 2'b00} +: 4]);
        else
          chr = subFf[0] ? wave_data.sample[7:0] : wave_data.sample[15:8];
        nxt_sub = subFf + 6'h01;
        if (lastWaveCh)
        begin
          nxt_sub = 6'h00;
          if (wave_data.last)
            nxt_state = frso_pkg::ST_IDLE;
        end
      end
      frso_pkg::ST_DRAIN:
      begin
        // unsent waveforms are still consumed so the source never stalls
        if (wave_valid && wave_data.last)
          nxt_state = frso_pkg::ST_IDLE;
      end
      default:
        nxt_state = frso_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stateFf <= frso_pkg::ST_IDLE;
      subFf   <= 6'h00;
      fIdxFf  <= 3'h0;
    end
    else if (step && (stateFf != frso_pkg::ST_WAVE || wave_valid))
    begin
      stateFf <= nxt_state;
      subFf   <= nxt_sub;
      fIdxFf  <= nxt_fIdx;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      resFf    <= '0;
      waveGoFf <= 1'b0;
      tookFf   <= 1'b0;
    end
    else
    begin
      tookFf <= res_valid & res_ready;
      if (res_valid && res_ready)
      begin
        resFf    <= res_data;
        waveGoFf <= sendWave;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      recCntFf  <= 8'h00;
      dropCntFf <= 8'h00;
    end
    else
    begin
      if (stateFf == frso_pkg::ST_TERM && load)
        recCntFf <= recCntFf + 8'h01;
      if (res_valid && res_ready && !sendRec)
        dropCntFf <= dropCntFf + 8'h01;
    end
  end

  // hsize is accepted but only whole-word transfers are meaningful
  logic unusedHsize;
  assign unusedHsize = ^hsize;

endmodule
`default_nettype wire

// >>> shared/frso_regs.svh
// register offsets, field positions, reset values and timing constants
`ifndef FRSO_REGS_SVH
`define FRSO_REGS_SVH

// --------------------------------------------------------------
// register byte offsets
// --------------------------------------------------------------
`define FRSO_CFG0_OFS   8'h00
`define FRSO_CFG1_OFS   8'h04
`define FRSO_STAT_OFS   8'h08
`define FRSO_ID_OFS     8'h40
`define FRSO_ID_WORDS   12
`define FRSO_ID_LAST    8'h6c

// --------------------------------------------------------------
// cfg0 fields
// --------------------------------------------------------------
`define FRSO_STN        4:0
`define FRSO_FLT        9:8
`define FRSO_FORM       13:12
`define FRSO_BAUD       17:16
`define FRSO_LEN8       20
`define FRSO_STOP2      21
`define FRSO_PAR        25:24
`define FRSO_CFG0_MASK  32'h0333_331f
`define FRSO_CFG0_RST   32'h0011_0001

// --------------------------------------------------------------
// cfg1 fields
// --------------------------------------------------------------
`define FRSO_FEN        7:0
`define FRSO_IDEN       8
`define FRSO_WSEL       13:12
`define FRSO_WENC       16
`define FRSO_IDCNT      29:24
`define FRSO_CFG1_MASK  32'h3f01_31ff
`define FRSO_CFG1_RST   32'h0000_101f

// --------------------------------------------------------------
// limits and codes
// --------------------------------------------------------------
`define FRSO_STN_MAX    5'h19
`define FRSO_ID_MAX     6'h30
`define FRSO_VERDICT    3'h3
`define FRSO_CH_HASH    8'h23
`define FRSO_CH_CR      8'h0d
`define FRSO_CH_LF      8'h0a
`define FRSO_CH_ENQ     8'h05
`define FRSO_CH_END     8'h03
`define FRSO_CH_ZERO    8'h30

// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define FRSO_CLK_HZ     100000000
`define FRSO_BPS_0      4800
`define FRSO_BPS_1      9600
`define FRSO_BPS_2      19200

`endif

// >>> shared/frso_pkg.sv
// types shared by the fastening result serial output
package frso_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_HEAD  = 3'b001,
    ST_STN   = 3'b010,
    ST_FIELD = 3'b011,
    ST_IDD   = 3'b100,
    ST_TERM  = 3'b101,
    ST_WAVE  = 3'b110,
    ST_DRAIN = 3'b111
  } frso_state_e;

  // field order: torque, pulse, duration, verdict, angle, freerun, seating, slope
  typedef struct packed {
    logic [7:0][15:0] field;
    logic             reject;
    logic             reportErr;
    logic             hasWave;
  } frso_result_s;

  typedef struct packed {
    logic [15:0] sample;
    logic        last;
  } frso_wave_s;

endpackage

// >>> tb/frso_host_model.sv
// serial host model that decodes characters from the transmit line
`timescale 1ns/1ps
`default_nettype none
module frso_host_model (
  input  wire logic        txd,
  input  wire logic [15:0] bitCyc,
  input  wire logic        len8,
  input  wire logic        stop2,
  input  wire logic [1:0]  par,
  output logic [7:0]       rxByte,
  output logic             rxStb,
  output logic             rxBad
);
  // ------
  // receiver, sampling each bit at its middle
  // ------
  // listens only, so it never loads the line
  realtime bitT;
  logic    pBit;
  initial
  begin
    rxByte = 8'h00;
    rxStb  = 1'b0;
    rxBad  = 1'b0;
    forever
    begin
      @(negedge txd);
      bitT = bitCyc * 10.0;
      #(bitT / 2);
      rxBad  = txd;
      rxByte = 8'h00;
      for (int i = 0; i < (len8 ? 8 : 7); i++)
      begin
        #(bitT);
        rxByte[i] = txd;
      end
      if (par == 2'h1 || par == 2'h2)
      begin
        #(bitT);
        pBit = ^rxByte ^ (par == 2'h2);
        if (txd !== pBit) rxBad = 1'b1;
      end
      repeat (stop2 ? 2 : 1)
      begin
        #(bitT);
        if (txd !== 1'b1) rxBad = 1'b1;
      end
      rxStb = 1'b1;
      #1 rxStb = 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> tb/frso_top_properties.sv
// port checks for the fastening result serial output
`timescale 1ns/1ps
`default_nettype none
module frso_top_properties #(
  parameter int BIT_CYC_0 = 16,
  parameter int BIT_CYC_1 = 8,
  parameter int BIT_CYC_2 = 4
)(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic        hreadyout,
  input  wire logic        hresp,
  input  wire logic [31:0] hrdata,
  input  wire logic        res_valid,
  input  wire logic        res_ready,
  input  wire logic        wave_valid,
  input  wire logic        wave_ready,
  input  wire logic        txd
);
  // ------
  // helper logic
  // ------
  logic        rdPh_ff;
  logic [31:0] lowRun_ff;
  logic [31:0] hiRun_ff;
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n) hiRun_ff <= 32'h0;
    else if (!txd) hiRun_ff <= 32'h0;
    else hiRun_ff <= hiRun_ff + 32'h1;
  end
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n) rdPh_ff <= 1'b0;
    else if (hready) rdPh_ff <= hsel && htrans[1] && !hwrite;
  end
  // counts a low run so a start bit shorter than the fastest bit is caught
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n) lowRun_ff <= 32'h0;
    else if (txd) lowRun_ff <= 32'h0;
    else lowRun_ff <= lowRun_ff + 32'h1;
  end
  // ------
  // properties
  // ------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_take; hsel && hready && htrans[1]; endsequence
  sequence s_rdWait; !hreadyout ##1 hreadyout; endsequence
  property p_okay; !hresp; endproperty
  property p_rdWait; s_take and !hwrite |=> s_rdWait; endproperty
  property p_wrNoWait; s_take and hwrite |=> hreadyout; endproperty
  property p_oneWait; !hreadyout |=> hreadyout; endproperty
  property p_rdHold; $changed(hrdata) |-> rdPh_ff; endproperty
  property p_readyDrop; res_valid && res_ready |=> !res_ready; endproperty
  // after a line quiet longer than any frame, a start bit needs a record in flight
  property p_startBusy;
    $fell(txd) && hiRun_ff > 12 * BIT_CYC_0 |-> !$past(res_ready);
  endproperty
  property p_startLen; $rose(txd) |-> lowRun_ff >= BIT_CYC_2; endproperty
  property p_wave; wave_ready |-> wave_valid; endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  a_rdWait: assert property (p_rdWait) else $error("read wait state wrong");
  a_wrNoWait: assert property (p_wrNoWait) else $error("write stalled");
  a_oneWait: assert property (p_oneWait) else $error("wait state too long");
  a_rdHold: assert property (p_rdHold) else $error("read data moved");
  a_readyDrop: assert property (p_readyDrop) else $error("record ready stayed high");
  a_startBusy: assert property (p_startBusy) else $error("start bit while idle");
  a_startLen: assert property (p_startLen) else $error("low run too short");
  a_wave: assert property (p_wave) else $error("sample taken without valid");
endmodule
bind frso_top frso_top_properties #(
  .BIT_CYC_0(BIT_CYC_0),
  .BIT_CYC_1(BIT_CYC_1),
  .BIT_CYC_2(BIT_CYC_2)
) u_props (
  .core_clk(core_clk),
  .reset_n(reset_n),
  .hsel(hsel),
  .htrans(htrans),
  .hwrite(hwrite),
  .hready(hready),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .hrdata(hrdata),
  .res_valid(res_valid),
  .res_ready(res_ready),
  .wave_valid(wave_valid),
  .wave_ready(wave_ready),
  .txd(txd)
);
`default_nettype wire

// >>> tb/test_fastening_result_serial_output.sv
// self-checking bench for the fastening result serial output
`timescale 1ns/1ps
`default_nettype none
`include "frso_regs.svh"
module test_fastening_result_serial_output;
  logic                   core_clk;
  logic                   reset_n;
  logic [31:0]            haddr;
  logic [1:0]             htrans;
  logic                   hwrite;
  logic [31:0]            hwdata;
  logic                   hreadyout;
  logic                   hresp;
  logic [31:0]            hrdata;
  logic                   res_valid;
  frso_pkg::frso_result_s res_data;
  logic                   res_ready;
  logic                   wave_valid;
  frso_pkg::frso_wave_s   wave_data;
  logic                   wave_ready;
  logic                   txd;
  logic [15:0]            mBit;
  logic [1:0]             mPar;
  logic                   mLen8;
  logic                   mStop2;
  logic [7:0]             rxByte;
  logic                   rxStb;
  logic                   rxBad;
  int                     errors;
  int                     num_checks;
  logic [7:0]             got[$];
  logic [7:0]             exq[$];
  localparam logic [31:0] WA[6] = '{32'h0, 32'h0, 32'h0, 32'h4, 32'h4, 32'h20};
  localparam logic [31:0] WD[6] = '{32'h1a, 32'h0, 32'h110019, 32'h3100001f,
                                    32'h3000001f, 32'hffffffff};
  localparam logic [31:0] ED[6] = '{32'h1, 32'h1, 32'h110019, 32'h1f, 32'h3000001f, 32'h0};
  localparam logic [31:0] C0[10] = '{32'h110001, 32'h1221019, 32'h2102007, 32'h110103,
    32'h110103, 32'h110201, 32'h110001, 32'h110001, 32'h110001, 32'h110001};
  localparam logic [31:0] C1[10] = '{32'h101f, 32'hff, 32'h0, 32'h101f, 32'h101f,
    32'h101f, 32'h1001, 32'h2000, 32'h12000, 32'h0};
  localparam logic [2:0] FL[10] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h3, 3'h1, 3'h1, 3'h5, 3'h1};

  // small bit counts keep each record to a few thousand cycles
  frso_top #(.BIT_CYC_0(16), .BIT_CYC_1(8), .BIT_CYC_2(4)) dut_u (
    .core_clk(core_clk), .reset_n(reset_n), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .res_valid(res_valid), .res_data(res_data), .res_ready(res_ready),
    .wave_valid(wave_valid), .wave_data(wave_data), .wave_ready(wave_ready), .txd(txd));
  frso_host_model host_u (.txd(txd), .bitCyc(mBit), .len8(mLen8), .stop2(mStop2),
    .par(mPar), .rxByte(rxByte), .rxStb(rxStb), .rxBad(rxBad));

  // ------
  // shared tasks
  // ------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    if (errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge core_clk);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    @(posedge core_clk iff hreadyout);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk iff hreadyout);
    r = hrdata;
  endtask
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction
  function automatic logic [15:0] fv(input int i);
    return 16'hab0c + 16'(i) * 16'h1111;
  endfunction

  // ------
  // scenarios
  // ------
  task automatic regTest();
    logic [31:0] r;
    ahb(1'b0, 32'h0, 32'h0, r);
    chk("cfg0", `FRSO_CFG0_RST, r);
    ahb(1'b0, 32'h4, 32'h0, r);
    chk("cfg1", `FRSO_CFG1_RST, r);
    ahb(1'b0, 32'h8, 32'h0, r);
    chk("status", 32'h2, r);
    for (int i = 0; i < 6; i++)
    begin
      ahb(1'b1, WA[i], WD[i], r);
      ahb(1'b0, WA[i], 32'h0, r);
      chk("regWrite", ED[i], r);
    end
  endtask
  task automatic runRec(input logic [31:0] c0, input logic [31:0] c1, input logic [2:0] fl);
    logic [31:0] r;
    logic [15:0] v;
    logic [7:0]  m;
    m = c0[20] ? 8'hff : 8'h7f;
    exq.delete();
    got.delete();
    if (c0[9:8] == 2'h0 || (c0[9:8] == 2'h1 && fl[1]))
    begin
      exq.push_back(c0[13:12] == 2'h2 ? `FRSO_CH_ENQ : `FRSO_CH_HASH);
      exq.push_back(8'h30 + 8'(c0[4:0] / 5'ha));
      exq.push_back(8'h30 + 8'(c0[4:0] % 5'ha));
      for (int i = 0; i < 8; i++)
      begin
        v = fv(i);
        if (c1[i] && i == 3) exq.push_back(hx(v[3:0]));
        else if (c1[i]) for (int k = 3; k >= 0; k--) exq.push_back(hx(v[4*k +: 4]));
      end
      exq.push_back(c0[13:12] == 2'h0 ? `FRSO_CH_CR :
                    c0[13:12] == 2'h1 ? `FRSO_CH_LF : `FRSO_CH_END);
      v = wave_data.sample;
      if (fl[0] && (c1[13:12] == 2'h1 || (c1[13:12] == 2'h2 && fl[2])))
      begin
        if (c1[16]) for (int k = 3; k >= 0; k--) exq.push_back(hx(v[4*k +: 4]));
        else exq.push_back(v[15:8]);
        if (!c1[16]) exq.push_back(v[7:0]);
      end
    end
    ahb(1'b1, 32'h0, c0, r);
    ahb(1'b1, 32'h4, c1, r);
    mBit   = c0[17:16] == 2'h0 ? 16'h10 : c0[17:16] == 2'h2 ? 16'h4 : 16'h8;
    mLen8  = c0[20];
    mStop2 = c0[21];
    mPar   = c0[25:24];
    @(posedge core_clk);
    res_data.reject    <= fl[2];
    res_data.reportErr <= fl[1];
    res_data.hasWave   <= fl[0];
    res_valid          <= 1'b1;
    wave_valid         <= fl[0];
    @(posedge core_clk iff res_ready);
    res_valid <= 1'b0;
    @(posedge core_clk iff res_ready);
    repeat (400) @(posedge core_clk);
    chk("charCount", exq.size(), got.size());
    for (int j = 0; j < exq.size(); j++)
      chk("char", {24'h0, exq[j] & m}, {24'h0, got[j]});
  endtask

  // ------
  // clock, collection, watchdog and main sequence
  // ------
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge rxStb)
  begin
    got.push_back(rxByte);
    chk("frame", 32'h0, {31'h0, rxBad});
  end
  always @(posedge core_clk) if (wave_ready) wave_valid <= 1'b0;
  initial
  begin
    repeat (100000) @(posedge core_clk);
    errors++;
    give_verdict();
  end
  initial
  begin
    errors     = 0;
    num_checks = 0;
    reset_n    = 1'b0;
    haddr      = 32'h0;
    htrans     = 2'h0;
    hwrite     = 1'b0;
    hwdata     = 32'h0;
    res_valid  = 1'b0;
    wave_valid = 1'b0;
    res_data   = '0;
    wave_data  = {16'h1e5a, 1'b1};
    mBit       = 16'h8;
    mLen8      = 1'b1;
    mStop2     = 1'b0;
    mPar       = 2'h0;
    for (int i = 0; i < 8; i++) res_data.field[i] = fv(i);
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    regTest();
    for (int i = 0; i < 10; i++) runRec(C0[i], C1[i], FL[i]);
    give_verdict();
  end
endmodule
`default_nettype wire
